// *** verilog/apst_ctrl.sv ***
`timescale 1ns/1ns
`default_nettype none
module apst_ctrl
  import apst_pkg::*;
#(
  parameter int CYCLES_MS = CYCLES_PER_MS
)(
  // Clock and reset
  input  wire logic                I_CLOCK,
  input  wire logic                I_RESET_N,
  // Set feature word
  input  wire logic                I_SET_VALID,
  input  wire logic [31:0]         I_SET_DW11,
  // Table entries written from the host buffer
  input  wire logic                I_TBL_WR_VALID,
  input  wire logic [STATE_W-1:0]  I_TBL_WR_INDEX,
  input  wire logic [ENTRY_W-1:0]  I_TBL_WR_DATA,
  // Read-back request and completion word
  input  wire logic                I_GET_REQ,
  output logic                     O_GET_DONE,
  output logic [31:0]              O_GET_DW0,
  // Read-back data stream
  output logic                     O_RD_VALID,
  output logic [STATE_W-1:0]       O_RD_INDEX,
  output logic [ENTRY_W-1:0]       O_RD_DATA,
  input  wire logic                I_RD_READY,
  // Activity and host-directed power state
  input  wire logic                I_CMD_ACTIVE,
  input  wire logic                I_PS_SET_VALID,
  input  wire logic [STATE_W-1:0]  I_PS_SET_STATE,
  // Power state out
  output logic [STATE_W-1:0]       O_POWER_STATE,
  output logic                     O_AUTO_MOVE,
  output logic                     O_AUTO_ENABLE
);

  // Registered state and its next value
  apst_state_t st_ff;
  apst_state_t nxt_st;

  // Timing and move helpers
  logic        ms_tick;
  logic        restart;
  apst_entry_t cur;
  logic        go_auto;
  logic        ps_change;
  logic        thr_set;
  logic        thr_over;
  logic        quiet;
  logic        idle_full;

  // Entry of the state we are in now
  // A host-set state outside the supported set reads a zero entry and never moves
  assign cur = st_ff.table_q[st_ff.power_state];

  // RL9: zero threshold blocks
  assign thr_set = (cur.idle_time_threshold_ms != '0);

  // RL10: strictly exceeds threshold
  assign thr_over = (st_ff.idle_ms > cur.idle_time_threshold_ms);

  // No command and no host-directed change this cycle
  assign quiet = !I_CMD_ACTIVE && !I_PS_SET_VALID;

  // RL1: only when enabled
  assign go_auto = st_ff.auto_transition_enable && quiet && thr_set && thr_over;

  // Saturation point, so a long idle never wraps back below the threshold
  assign idle_full = (st_ff.idle_ms == '1);

  // Any change of state, host-directed or autonomous
  assign ps_change = go_auto || I_PS_SET_VALID;

  // RL13: restart idle timing
  assign restart = I_CMD_ACTIVE || ps_change;

  // Millisecond base, realigned on every restart
  apst_ms_tick #(
    .CYCLES    (CYCLES_MS)
  ) u_tick (
    .i_clock   (I_CLOCK),
    .i_reset_n (I_RESET_N),
    .i_restart (restart),
    .o_tick    (ms_tick)
  );

  // RL14: reserved entry bits dropped
  // RL8: idle field in ms
  function automatic apst_entry_t word_to_entry(input logic [ENTRY_W-1:0] w);
    apst_entry_t e;
    e.idle_time_threshold_ms = w[IDLE_MSB:IDLE_LSB];
    e.idle_target_state      = w[TGT_MSB:TGT_LSB];
    return e;
  endfunction : word_to_entry

  // Next-state logic for configuration, timing and read-back
  always_comb
  begin
    nxt_st          = st_ff;
    nxt_st.moved    = 1'b0;
    nxt_st.get_done = 1'b0;

    // RL14: only bit 0 kept
    if (I_SET_VALID)
    begin
      nxt_st.auto_transition_enable = I_SET_DW11[EN_BIT];
    end

    // RL5: unsupported stay zero
    // RL6: index is the power state
    if (I_TBL_WR_VALID)
    begin
      if (SUPPORTED[I_TBL_WR_INDEX])
      begin
        nxt_st.table_q[I_TBL_WR_INDEX] = word_to_entry(I_TBL_WR_DATA);
      end
      else
      begin
        nxt_st.table_q[I_TBL_WR_INDEX] = '0;
      end
    end

    // RL8: whole milliseconds idle
    // RL13: restart clears count
    if (restart)
    begin
      nxt_st.idle_ms = '0;
    end
    else if (ms_tick && !idle_full)
    begin
      nxt_st.idle_ms = st_ff.idle_ms + IDLE_W'(1);
    end

    // Host-directed change wins over an autonomous one in the same cycle
    if (I_PS_SET_VALID)
    begin
      nxt_st.power_state = I_PS_SET_STATE;
    end
    else if (go_auto)
    begin
      nxt_st.power_state = cur.idle_target_state;
      nxt_st.moved       = 1'b1;
    end

    // RL3: completion word and table
    case (st_ff.rb)
      RB_IDLE:
      begin
        // A request during a stream is never seen here, so it is dropped
        if (I_GET_REQ)
        begin
          nxt_st.get_dw0         = '0;
          nxt_st.get_dw0[EN_BIT] = st_ff.auto_transition_enable;
          nxt_st.get_done        = 1'b1;
          nxt_st.rb              = RB_SEND;
          nxt_st.rb_index        = '0;
          nxt_st.rd_valid        = 1'b1;
          nxt_st.rd_data         = entry_to_word(st_ff.table_q[0]);
        end
      end
      RB_SEND:
      begin
        // Beat stands until the consumer takes it
        if (I_RD_READY)
        begin
          // RL4: all 32 entries sent
          if (st_ff.rb_index == STATE_W'(NUM_STATES - 1))
          begin
            nxt_st.rb       = RB_IDLE;
            nxt_st.rd_valid = 1'b0;
            nxt_st.rd_data  = '0;
          end
          else
          begin
            // Next entry read live, so a late table write still shows
            nxt_st.rb_index = st_ff.rb_index + STATE_W'(1);
            nxt_st.rd_data  =
              entry_to_word(st_ff.table_q[st_ff.rb_index + STATE_W'(1)]);
          end
        end
      end
      default:
      begin
        nxt_st.rb       = RB_IDLE;
        nxt_st.rd_valid = 1'b0;
      end
    endcase
  end

  // State register
  always_ff @(posedge I_CLOCK or negedge I_RESET_N)
  begin
    if (!I_RESET_N)
    begin
      // Clear all, then name the fields whose reset matters
      st_ff                        <= '0;
      // RL2: enable off at reset
      st_ff.auto_transition_enable <= EN_RESET;
      st_ff.power_state            <= PS_RESET;
      st_ff.rb                     <= RB_IDLE;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  // Read-back outputs straight from the state register
  assign O_GET_DONE    = st_ff.get_done;
  assign O_GET_DW0     = st_ff.get_dw0;
  assign O_RD_VALID    = st_ff.rd_valid;
  assign O_RD_INDEX    = st_ff.rb_index;
  assign O_RD_DATA     = st_ff.rd_data;

  // Power state outputs, registered as well
  assign O_POWER_STATE = st_ff.power_state;
  assign O_AUTO_MOVE   = st_ff.moved;
  assign O_AUTO_ENABLE = st_ff.auto_transition_enable;

endmodule : apst_ctrl
`default_nettype wire

// *** verilog/apst_pkg.sv ***
// Functional notes
// RL1: Autonomous power state moves happen only while the enable bit 0 of the feature word is one.
// RL2: The enable bit comes up zero after reset, so moves stay off until the host sets it.
// RL3: A read-back returns the enable in completion word 0 and streams the whole table as data.
// RL4: The table holds 32 entries of 64 bits, one for every allowable power state.
// RL5: Every entry of an unsupported power state is all zeroes.
// RL6: Entry n sits at bytes 8n+7 down to 8n, so state 0 is bytes 7:0 and state 1 bytes 15:8.
// RL7: The host hands the table over as one contiguous 256-byte buffer.
// RL8: Entry bits 31:8 give the idle time in milliseconds before a move out of that state.
// RL9: An idle time of zero means no autonomous move out of that state.
// RL10: Once continuous idle exceeds the threshold, the state moves to entry bits 7:3.
// RL11: The host programs only non-operational states as targets.
// RL12: The host should not pick a target with higher idle power than the current state.
// RL13: The idle timer restarts on any command activity and on entering a new power state.
// RL14: Reserved bits of the feature word and the entries are ignored and read back as zero.
package apst_pkg;

  // Table geometry
  localparam int NUM_STATES    = 32;
  localparam int STATE_W       = 5;
  localparam int ENTRY_W       = 64;
  localparam int IDLE_W        = 24;
  localparam int TABLE_BYTES   = 256;

  // Field positions in the feature word and in an entry
  localparam int EN_BIT        = 0;
  localparam int IDLE_LSB      = 8;
  localparam int IDLE_MSB      = 31;
  localparam int TGT_LSB       = 3;
  localparam int TGT_MSB       = 7;

  // Reset values and the mask of supported power states
  localparam logic                  EN_RESET    = 1'b0;
  localparam logic [STATE_W-1:0]    PS_RESET    = 5'h00;
  localparam logic [NUM_STATES-1:0] SUPPORTED   = 32'h0000001F;

  // Timing: one millisecond at a 40 ns clock
  localparam int MS_NS         = 1000000;
  localparam int CLK_NS        = 40;
  localparam int CYCLES_PER_MS = MS_NS / CLK_NS;
  localparam int TICK_W        = 15;

  // Stored part of one entry, reserved bits dropped
  typedef struct packed {
    logic [IDLE_W-1:0]  idle_time_threshold_ms;
    logic [STATE_W-1:0] idle_target_state;
  } apst_entry_t;

  // Read-back sequencer, one-hot
  typedef enum logic [1:0] {
    RB_IDLE = 2'h1,
    RB_SEND = 2'h2
  } rb_state_t;

  // Whole state of the controller
  typedef struct packed {
    logic                          auto_transition_enable;
    apst_entry_t [NUM_STATES-1:0]  table_q;
    logic [STATE_W-1:0]            power_state;
    logic [IDLE_W-1:0]             idle_ms;
    logic                          moved;
    rb_state_t                     rb;
    logic [STATE_W-1:0]            rb_index;
    logic                          rd_valid;
    logic [ENTRY_W-1:0]            rd_data;
    logic                          get_done;
    logic [31:0]                   get_dw0;
  } apst_state_t;

  // Millisecond tick generator state
  typedef struct packed {
    logic [TICK_W-1:0] count;
    logic              tick;
  } tick_state_t;

  // Expand a stored entry into its 64-bit wire form, reserved bits zero
  function automatic logic [ENTRY_W-1:0] entry_to_word(input apst_entry_t e);
    logic [ENTRY_W-1:0] w;
    w = '0;
    w[IDLE_MSB:IDLE_LSB] = e.idle_time_threshold_ms;
    w[TGT_MSB:TGT_LSB]   = e.idle_target_state;
    return w;
  endfunction : entry_to_word

endpackage : apst_pkg

// *** verilog/apst_ms_tick.sv ***
`timescale 1ns/1ns
`default_nettype none
module apst_ms_tick
  import apst_pkg::*;
#(
  parameter int CYCLES = CYCLES_PER_MS
)(
  // Clock and reset
  input  wire logic i_clock,
  input  wire logic i_reset_n,
  // Control
  input  wire logic i_restart,
  // Tick out
  output logic      o_tick
);

  tick_state_t st_ff;
  tick_state_t nxt_st;

  localparam logic [TICK_W-1:0] LAST = TICK_W'(CYCLES - 1);

  // Restart realigns the millisecond so idle time is measured from the restart
  always_comb
  begin
    nxt_st      = st_ff;
    nxt_st.tick = 1'b0;
    if (i_restart)
    begin
      nxt_st.count = '0;
    end
    else if (st_ff.count == LAST)
    begin
      nxt_st.count = '0;
      nxt_st.tick  = 1'b1;
    end
    else
    begin
      nxt_st.count = st_ff.count + TICK_W'(1);
    end
  end

  // State register
  always_ff @(posedge i_clock or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      st_ff <= '0;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  assign o_tick = st_ff.tick;

endmodule : apst_ms_tick
`default_nettype wire

// *** verification/apst_ctrl_properties.sv ***
`timescale 1ns/1ns
`default_nettype none
module apst_ctrl_properties
  import apst_pkg::*;
#(
  parameter int CYCLES_MS = CYCLES_PER_MS
)(
  // Clock, reset, inputs
  input wire logic        I_CLOCK,
  input wire logic        I_RESET_N,
  input wire logic        I_SET_VALID,
  input wire logic [31:0] I_SET_DW11,
  input wire logic        I_GET_REQ,
  input wire logic        I_RD_READY,
  input wire logic        I_CMD_ACTIVE,
  input wire logic        I_PS_SET_VALID,
  input wire logic [4:0]  I_PS_SET_STATE,
  // Outputs
  input wire logic        O_GET_DONE,
  input wire logic [31:0] O_GET_DW0,
  input wire logic        O_RD_VALID,
  input wire logic [4:0]  O_RD_INDEX,
  input wire logic [63:0] O_RD_DATA,
  input wire logic [4:0]  O_POWER_STATE,
  input wire logic        O_AUTO_MOVE,
  input wire logic        O_AUTO_ENABLE
);
  // One domain, so clock and reset are given once
  default clocking cb @(posedge I_CLOCK);
  endclocking
  default disable iff (!I_RESET_N);
  chk_reset_clear: assert property (
    $rose(I_RESET_N) |-> !O_AUTO_ENABLE && O_POWER_STATE == 5'h00) else $error("not clear");
  chk_enable_take: assert property (
    I_SET_VALID |=> O_AUTO_ENABLE == $past(I_SET_DW11[0])) else $error("enable");
  chk_off_still: assert property (
    !O_AUTO_ENABLE |=> !O_AUTO_MOVE) else $error("move while off");
  chk_get_answer: assert property (
    I_GET_REQ && !O_RD_VALID && !I_SET_VALID |=> O_GET_DONE && O_RD_VALID
      && O_RD_INDEX == 5'h00 && O_GET_DW0 == {31'h0, O_AUTO_ENABLE}) else $error("get");
  chk_beat_hold: assert property (
    O_RD_VALID && !I_RD_READY |=> O_RD_VALID && $stable(O_RD_INDEX)) else $error("hold");
  chk_beat_step: assert property (
    O_RD_VALID && I_RD_READY && O_RD_INDEX != 5'h1F
      |=> O_RD_VALID && O_RD_INDEX == $past(O_RD_INDEX) + 5'h01) else $error("order");
  chk_stream_end: assert property (
    O_RD_VALID && I_RD_READY && O_RD_INDEX == 5'h1F |=> !O_RD_VALID) else $error("end");
  chk_rsvd_zero: assert property (
    O_RD_VALID |-> O_RD_DATA[63:32] == 32'h0 && O_RD_DATA[2:0] == 3'h0) else $error("rsvd");
  // Smallest threshold is 1 ms of at least 4 cycles, so 8 quiet cycles
  chk_busy_quiet: assert property (
    I_CMD_ACTIVE |=> !O_AUTO_MOVE [*8]) else $error("move while busy");
  chk_host_state: assert property (
    I_PS_SET_VALID |=> O_POWER_STATE == $past(I_PS_SET_STATE) && !O_AUTO_MOVE)
    else $error("host state");
  cover property (O_AUTO_MOVE);
  cover property (O_RD_VALID && I_RD_READY && O_RD_INDEX == 5'h1F);
  cover property (O_GET_DONE && O_GET_DW0[0]);
endmodule : apst_ctrl_properties
bind apst_ctrl apst_ctrl_properties #(.CYCLES_MS(CYCLES_MS)) u_props (
  .I_CLOCK, .I_RESET_N, .I_SET_VALID, .I_SET_DW11, .I_GET_REQ, .I_RD_READY,
  .I_CMD_ACTIVE, .I_PS_SET_VALID, .I_PS_SET_STATE, .O_GET_DONE, .O_GET_DW0,
  .O_RD_VALID, .O_RD_INDEX, .O_RD_DATA, .O_POWER_STATE, .O_AUTO_MOVE, .O_AUTO_ENABLE
);
`default_nettype wire

// *** verification/apst_host_model.sv ***
`timescale 1ns/1ns
`default_nettype none
module apst_host_model
  import apst_pkg::*;
(
  // Clock, reset, bench control
  input  wire logic   i_clk,
  input  wire logic   i_rst_n,
  input  wire logic   i_load,
  input  wire logic   i_slow,
  // Table writes and read-back acceptance
  output logic        o_wr_valid,
  output logic [4:0]  o_wr_index,
  output logic [63:0] o_wr_data,
  output logic        o_ready
);
  logic       tog;
  logic       vn;
  logic [4:0] nx;
  // reserved bits set on purpose; targets are deeper states
  function automatic logic [63:0] ent(input logic [4:0] n);
    if (n > 5'h04)
      return 64'h0;
    if (n > 5'h02)
      return 64'hFFFFFFFF_00000007;
    return {32'hFFFFFFFF, 19'h0, n + 5'h01, n + 5'h02, 3'h7};
  endfunction : ent
  // Slow mode accepts a beat every other cycle
  assign o_ready = !i_slow || tog;
  assign vn      = i_load || (o_wr_valid && o_wr_index != 5'h1F);
  assign nx      = o_wr_valid ? o_wr_index + 5'h01 : 5'h00;
  // the 256-byte table, one entry per state in order
  always_ff @(posedge i_clk or negedge i_rst_n)
    if (!i_rst_n)
    begin
      tog        <= 1'b0;
      o_wr_valid <= 1'b0;
      o_wr_index <= 5'h00;
      o_wr_data  <= 64'h0;
    end
    else
    begin
      tog        <= !tog;
      o_wr_valid <= vn;
      o_wr_index <= nx;
      o_wr_data  <= vn ? ent(nx) : ~o_wr_data;
    end
endmodule : apst_host_model
`default_nettype wire

// *** verification/tb.sv ***
`timescale 1ns/1ns
`default_nettype none
module tb;
  import apst_pkg::*;
  localparam int C = 4;
  logic        clk, rst_n, set_v, get, act, ps_v, load, slow;
  logic        done, rv, rdy, wv, mv, en;
  logic [31:0] dw11, dw0;
  logic [4:0]  ps, ridx, widx, pst;
  logic [63:0] rd, wd;
  int          error_cnt = 0;
  int          tests_run = 0;
  apst_ctrl #(.CYCLES_MS(C)) DUT (
    .I_CLOCK(clk), .I_RESET_N(rst_n), .I_SET_VALID(set_v), .I_SET_DW11(dw11),
    .I_TBL_WR_VALID(wv), .I_TBL_WR_INDEX(widx), .I_TBL_WR_DATA(wd), .I_GET_REQ(get),
    .O_GET_DONE(done), .O_GET_DW0(dw0), .O_RD_VALID(rv), .O_RD_INDEX(ridx),
    .O_RD_DATA(rd), .I_RD_READY(rdy), .I_CMD_ACTIVE(act), .I_PS_SET_VALID(ps_v),
    .I_PS_SET_STATE(ps), .O_POWER_STATE(pst), .O_AUTO_MOVE(mv), .O_AUTO_ENABLE(en));
  apst_host_model host (.i_clk(clk), .i_rst_n(rst_n), .i_load(load), .i_slow(slow),
    .o_wr_valid(wv), .o_wr_index(widx), .o_wr_data(wd), .o_ready(rdy));
  initial
  begin
    clk = 1'b0;
    forever #20 clk = !clk;
  end
  task automatic chk(input logic [63:0] got, exp);
    tests_run++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("unexpected %0t: %h vs %h", $time, got, exp);
    end
  endtask : chk
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step
  // Feature word when s is high, host-set power state otherwise
  task automatic cmd(input logic s, input logic [31:0] d);
    dw11 = d;
    ps = d[4:0];
    if (s)
      set_v = 1'b1;
    else
      ps_v = 1'b1;
    step(1);
    if (s)
      set_v = 1'b0;
    else
      ps_v = 1'b0;
  endtask : cmd
  // Counts cycles to the next move; lo above hi means none is allowed
  task automatic wait_mv(input int lo, hi, input logic [4:0] st);
    int n;
    @(negedge clk);
    n = 1;
    while (mv !== 1'b1 && n <= hi)
    begin
      @(negedge clk);
      n++;
    end
    chk(64'(n >= lo && (n <= hi || lo > hi)), 64'h1);
    chk(64'(pst), 64'(st));
    step(1);
  endtask : wait_mv
  task automatic t_read(input logic e);
    get = 1'b1;
    step(1);
    get = 1'b0;
    @(negedge clk);
    chk(64'({done, dw0}), {31'h0, 1'b1, 31'h0, e});
    for (int k = 0; k < 32; k++)
    begin
      while (!(rv === 1'b1 && rdy === 1'b1))
        @(negedge clk);
      chk(64'(ridx), 64'(k));
      chk(rd, k < 3 ? {32'h0, 24'(k + 1), 5'(k + 2), 3'h0} : 64'h0);
      @(negedge clk);
    end
    chk(64'(rv), 64'h0);
    $display("read-back done");
    step(1);
  endtask : t_read
  task automatic t_table;
    load = 1'b1;
    step(1);
    load = 1'b0;
    step(34);
    slow = 1'b1;
    cmd(1'b1, 32'hFFFFFFFE);
    chk(64'(en), 64'h0);
    t_read(1'b0);
    slow = 1'b0;
    cmd(1'b1, 32'h1);
    t_read(1'b1);
  endtask : t_table
  task automatic t_off;
    cmd(1'b1, 32'hFFFFFFFE);
    cmd(1'b0, 32'h0);
    wait_mv(41, 40, 5'h00);
    $display("disabled done");
  endtask : t_off
  task automatic t_chain;
    cmd(1'b1, 32'h1);
    cmd(1'b0, 32'h0);
    wait_mv(2 * C, 2 * C + 4, 5'h02);
    wait_mv(4 * C, 4 * C + 4, 5'h04);
    wait_mv(41, 40, 5'h04);
    $display("chain done");
  endtask : t_chain
  task automatic t_busy;
    cmd(1'b0, 32'h0);
    act = 1'b1;
    step(20);
    act = 1'b0;
    wait_mv(2 * C, 2 * C + 4, 5'h02);
    $display("activity done");
  endtask : t_busy
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : print_verdict
  initial
  begin
    {rst_n, set_v, get, act, ps_v, load, slow} = 7'h00;
    dw11 = 32'h0;
    ps = 5'h00;
    step(8);
    rst_n = 1'b1;
    step(1);
    chk(64'({en, pst, mv, rv, done}), 64'h0);
    t_table;
    t_off;
    t_chain;
    t_busy;
    print_verdict;
  end
  // Tests need about 300 cycles; 3000 leaves room before calling it a hang
  initial
  begin
    #120000;
    error_cnt++;
    print_verdict;
  end
endmodule : tb
`default_nettype wire
